/* uarx_defines.svh */
// Constants for the receive status and interrupt block
`ifndef UARX_DEFINES_SVH
`define UARX_DEFINES_SVH
`define UARX_OVERSAMPLE 5'h10
`define UARX_MID_A 4'h6
`define UARX_MID_B 4'h7
`define UARX_MID_C 4'h8
`define UARX_LAST_TICK 4'hF
`define UARX_ADDR_STATUS 2'h0
`define UARX_ADDR_DATA 2'h1
`define UARX_ADDR_CTRL 2'h2
`define UARX_ADDR_BAUD 2'h3
`define UARX_CTRL_RESET 10'h000
`define UARX_BAUD_RESET 8'h00
`define UARX_ST_AVAIL 0
`define UARX_ST_OVR 1
`define UARX_ST_NOISE 2
`define UARX_ST_FRAME 3
`define UARX_ST_PAR 4
`define UARX_ST_IDLE 5
`define UARX_ST_TXIF 6
`define UARX_ST_TIDLE 7
`define UARX_CT_NINE 0
`define UARX_CT_PAREN 1
`define UARX_CT_PARODD 2
`define UARX_CT_TWOSTOP 3
`define UARX_CT_RXIE 4
`define UARX_CT_ADET 5
`define UARX_CT_TEIE 6
`define UARX_CT_TIIE 7
`define UARX_CT_WAKE 8
`define UARX_CT_RXEN 9
`endif

/* uarx_pkg.sv */
// Types shared by the receive status and interrupt block
package uarx_pkg;
    typedef enum logic [2:0] {
        UARX_IDLE,
        UARX_START,
        UARX_DATA,
        UARX_PARITY,
        UARX_STOP,
        UARX_STOP2,
        UARX_WAIT_HIGH
    } uarx_state_e;

    // One received word with its own error bits
    typedef struct packed {
        logic [8:0] data;
        logic fr_err;
        logic pa_err;
    } uarx_word_s;

    // Register port signals
    typedef struct packed {
        logic [1:0] addr;
        logic [9:0] wdata;
        logic wr;
        logic rd;
    } uarx_bus_s;
endpackage

/* uarx_sync.sv */
// Two-stage synchroniser with three-sample majority filter
`timescale 1ns/1ps
`include "uarx_defines.svh"
module uarx_sync (
    // Clock and control
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic sample_i,
    // Line
    input wire logic pin_i,
    output logic level_o,
    output logic sync_o,
    output logic vote_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic [2:0] win;
    } uarx_sync_s;

    uarx_sync_s st_ff;
    uarx_sync_s nxt_st;

    // Only s2 is looked at downstream; s1 feeds nothing else
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin_i;
        nxt_st.s2 = st_ff.s1;
        if (sample_i) begin
            nxt_st.win = {st_ff.win[1:0], st_ff.s2};
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_ff <= '1;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.s2;
    assign level_o = (st_ff.win[0] & st_ff.win[1]) | (st_ff.win[0] & st_ff.win[2]) | (st_ff.win[1] & st_ff.win[2]);
    // Samples that disagree mean noise on the line
    assign vote_o = ~((st_ff.win == 3'b000) | (st_ff.win == 3'b111));
endmodule

/* uarx_fifo.sv */
// Two-deep receive word buffer
`timescale 1ns/1ps
module uarx_fifo #(
    parameter int DEPTH = 2
) (
    // Clock and control
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Fill side
    input wire logic push_i,
    input wire uarx_pkg::uarx_word_s word_i,
    output logic full_o,
    // Drain side
    input wire logic pop_i,
    output uarx_pkg::uarx_word_s head_o,
    output logic empty_o
);
    typedef struct packed {
        uarx_pkg::uarx_word_s [DEPTH-1:0] mem;
        logic [1:0] cnt;
    } uarx_fifo_s;

    uarx_fifo_s st_ff;
    uarx_fifo_s nxt_st;
    logic do_pop;
    logic do_push;

    // Head is always slot 0; a pop shifts the rest down
    always_comb begin
        nxt_st = st_ff;
        do_pop = pop_i && (st_ff.cnt != 2'h0);
        do_push = push_i && ((st_ff.cnt != 2'(DEPTH)) || do_pop);
        if (do_pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                nxt_st.mem[i] = st_ff.mem[i + 1];
            end
        end
        if (do_push) begin
            nxt_st.mem[st_ff.cnt - 2'(do_pop)] = word_i;
        end
        nxt_st.cnt = st_ff.cnt + 2'(do_push) - 2'(do_pop);
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_ff <= '0;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign full_o = (st_ff.cnt == 2'(DEPTH));
    assign empty_o = (st_ff.cnt == 2'h0);
    assign head_o = st_ff.mem[0];
endmodule

/* uarx_core.sv */
// Serial receiver with status flags, two-word buffer and port interrupt
`timescale 1ns/1ps
`include "uarx_defines.svh"
module uarx_core (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Port clock running; low means clock stopped
    input wire logic port_clock_run_i,
    // Register port
    input wire logic [1:0] addr_i,
    input wire logic [9:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [9:0] rdata_o,
    // Transmitter state from outside
    input wire logic tx_empty_i,
    input wire logic tx_idle_i,
    // Line and interrupt
    input wire logic rx_pin_i,
    output logic irq_n_o,
    output logic receive_idle_flag_o
);
    localparam int DEPTH = 2;

    typedef struct packed {
        uarx_pkg::uarx_state_e state;
        logic [3:0] tick;
        logic [7:0] baud_cnt;
        logic [3:0] bitn;
        logic [8:0] receive_shift_register;
        logic noise;
        logic fr_err_acc;
        logic pa_err_acc;
        logic receive_available_flag;
        logic overrun_flag;
        logic noise_flag;
        logic receive_idle_flag;
        logic status_seen;
        logic [9:0] port_control_two;
        logic [7:0] baud;
        logic [9:0] rdata;
        logic irq_n;
        logic src_d;
        logic line_d;
    } uarx_core_s;

    uarx_core_s st_ff;
    uarx_core_s nxt_st;
    uarx_pkg::uarx_bus_s bus;
    uarx_pkg::uarx_word_s push_word;
    uarx_pkg::uarx_word_s head;
    logic sample_en;
    logic level;
    logic line;
    logic vote_bad;
    logic push;
    logic pop;
    logic full;
    logic empty;
    logic stop_done;
    logic tick_mid;
    logic word_top;
    logic rx_src;
    logic tx_src;
    logic wake;
    logic source;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign sample_en = (st_ff.baud_cnt == 8'h00);

    // Filter the line: sync then majority over three ticks
    uarx_sync u_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .sample_i(sample_en),
        .pin_i(rx_pin_i),
        .level_o(level),
        .sync_o(line),
        .vote_o(vote_bad)
    );

    uarx_fifo #(
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .push_i(push),
        .word_i(push_word),
        .full_o(full),
        .pop_i(pop),
        .head_o(head),
        .empty_o(empty)
    );

    // Pop on a data read that follows a status access
    assign pop = bus.rd && (bus.addr == `UARX_ADDR_DATA) && st_ff.status_seen && !empty;
    // Word completes on the last stop sample; full buffer and no pop loses it
    assign push = stop_done && (!full || pop);
    assign tick_mid = sample_en && (st_ff.tick == `UARX_MID_C);
    assign word_top = st_ff.port_control_two[`UARX_CT_NINE] ? push_word.data[8] : push_word.data[7];

    // Assemble the word handed to the buffer
    always_comb begin
        push_word.data = st_ff.receive_shift_register;
        if (!st_ff.port_control_two[`UARX_CT_NINE]) begin
            push_word.data = {1'b0, st_ff.receive_shift_register[8:1]};
        end
        push_word.fr_err = st_ff.fr_err_acc | (tick_mid & ~level);
        // Running xor is only a parity verdict while parity is on
        push_word.pa_err = st_ff.pa_err_acc & st_ff.port_control_two[`UARX_CT_PAREN];
        if (push_word.fr_err && (push_word.data == 9'h000)) begin
            push_word.data = 9'h000;
        end
    end

    // Stop sampled in last stop slot ends the frame
    always_comb begin
        stop_done = 1'b0;
        if (tick_mid) begin
            if (st_ff.state == uarx_pkg::UARX_STOP2) begin
                stop_done = 1'b1;
            end else if (st_ff.state == uarx_pkg::UARX_STOP && !st_ff.port_control_two[`UARX_CT_TWOSTOP]) begin
                stop_done = 1'b1;
            end
        end
    end

    // Interrupt sources; receive pair shares one enable
    always_comb begin
        rx_src = 1'b0;
        if (push && st_ff.port_control_two[`UARX_CT_RXIE]) begin
            if (!st_ff.port_control_two[`UARX_CT_ADET] || word_top) begin
                rx_src = 1'b1;
            end
        end
        if (stop_done && full && !pop && st_ff.port_control_two[`UARX_CT_RXIE]) begin
            rx_src = 1'b1;
        end
        tx_src = (tx_empty_i & st_ff.port_control_two[`UARX_CT_TEIE])
            | (tx_idle_i & st_ff.port_control_two[`UARX_CT_TIIE]);
        wake = !port_clock_run_i && st_ff.line_d && !line
            && st_ff.port_control_two[`UARX_CT_WAKE] && st_ff.port_control_two[`UARX_CT_RXIE];
        source = rx_src | wake | tx_src;
    end

    // Receiver sequencing, flags and register port
    always_comb begin
        nxt_st = st_ff;
        nxt_st.line_d = line;
        nxt_st.src_d = source;
        // Low pulse on each new request, one cycle wide
        nxt_st.irq_n = !(source && !st_ff.src_d);
        nxt_st.rdata = 10'h000;
        nxt_st.baud_cnt = sample_en ? st_ff.baud : st_ff.baud_cnt - 8'h01;

        // Receiver is paused while its port clock is off
        if (sample_en && port_clock_run_i && st_ff.port_control_two[`UARX_CT_RXEN]) begin
            nxt_st.tick = st_ff.tick + 4'h1;
            if ((st_ff.tick == `UARX_MID_A) || (st_ff.tick == `UARX_MID_B) || (st_ff.tick == `UARX_MID_C)) begin
                nxt_st.noise = st_ff.noise | vote_bad;
            end
            case (st_ff.state)
                uarx_pkg::UARX_IDLE: begin
                    nxt_st.tick = 4'h0;
                    if (!line) begin
                        nxt_st.state = uarx_pkg::UARX_START;
                        nxt_st.receive_idle_flag = 1'b0;
                        nxt_st.noise = 1'b0;
                        nxt_st.fr_err_acc = 1'b0;
                        nxt_st.pa_err_acc = 1'b0;
                        nxt_st.bitn = 4'h0;
                        nxt_st.receive_shift_register = 9'h000;
                    end
                end
                uarx_pkg::UARX_START: begin
                    if (tick_mid && level) begin
                        nxt_st.state = uarx_pkg::UARX_IDLE;
                        nxt_st.receive_idle_flag = 1'b1;
                    end else if (st_ff.tick == `UARX_LAST_TICK) begin
                        nxt_st.state = uarx_pkg::UARX_DATA;
                    end
                end
                uarx_pkg::UARX_DATA: begin
                    if (tick_mid) begin
                        // LSB first; the top bit lands in bit 8
                        nxt_st.receive_shift_register = {level, st_ff.receive_shift_register[8:1]};
                        nxt_st.pa_err_acc = st_ff.pa_err_acc ^ level;
                    end
                    if (st_ff.tick == `UARX_LAST_TICK) begin
                        nxt_st.bitn = st_ff.bitn + 4'h1;
                        if (st_ff.bitn == (st_ff.port_control_two[`UARX_CT_NINE] ? 4'h8 : 4'h7)) begin
                            nxt_st.state = st_ff.port_control_two[`UARX_CT_PAREN] ? uarx_pkg::UARX_PARITY
                                                                               : uarx_pkg::UARX_STOP;
                        end
                    end
                end
                uarx_pkg::UARX_PARITY: begin
                    if (tick_mid) begin
                        // Even parity: data xor parity is zero
                        nxt_st.pa_err_acc = st_ff.pa_err_acc ^ level ^ st_ff.port_control_two[`UARX_CT_PARODD];
                    end
                    if (st_ff.tick == `UARX_LAST_TICK) begin
                        nxt_st.state = uarx_pkg::UARX_STOP;
                    end
                end
                uarx_pkg::UARX_STOP: begin
                    if (tick_mid) begin
                        nxt_st.fr_err_acc = st_ff.fr_err_acc | ~level;
                        nxt_st.receive_idle_flag = 1'b1;
                    end
                    if (stop_done) begin
                        // A low stop may be a break: never take it as a start
                        nxt_st.state = level ? uarx_pkg::UARX_IDLE : uarx_pkg::UARX_WAIT_HIGH;
                    end else if (st_ff.tick == `UARX_LAST_TICK) begin
                        nxt_st.state = uarx_pkg::UARX_STOP2;
                    end
                end
                uarx_pkg::UARX_STOP2: begin
                    if (stop_done) begin
                        nxt_st.state = level ? uarx_pkg::UARX_IDLE : uarx_pkg::UARX_WAIT_HIGH;
                    end
                end
                uarx_pkg::UARX_WAIT_HIGH: begin
                    nxt_st.tick = 4'h0;
                    if (line) begin
                        nxt_st.state = uarx_pkg::UARX_IDLE;
                    end
                end
                default: begin
                    nxt_st.state = uarx_pkg::UARX_IDLE;
                end
            endcase
        end

        // Status access arms the clearing data read
        if ((bus.rd || bus.wr) && (bus.addr == `UARX_ADDR_STATUS)) begin
            nxt_st.status_seen = 1'b1;
        end else if (bus.rd && (bus.addr == `UARX_ADDR_DATA)) begin
            nxt_st.status_seen = 1'b0;
        end

        // Ordered pair clears flags; a same-cycle set wins
        if (pop) begin
            nxt_st.overrun_flag = 1'b0;
            nxt_st.noise_flag = 1'b0;
            nxt_st.receive_available_flag = 1'b0;
        end
        if (pop && DEPTH > 1) begin
            nxt_st.receive_available_flag = 1'b0;
        end
        if (stop_done && full && !pop) begin
            nxt_st.overrun_flag = 1'b1;
        end
        if (push) begin
            nxt_st.receive_available_flag = 1'b1;
            nxt_st.noise_flag = st_ff.noise | vote_bad;
        end
        if (pop && !push && (empty || full) == 1'b0) begin
            nxt_st.receive_available_flag = 1'b0;
        end
        if (pop && !push && full) begin
            // Second word still waits behind the one read
            nxt_st.receive_available_flag = 1'b1;
        end

        // Control writes; status flags are never writable
        if (bus.wr) begin
            if (bus.addr == `UARX_ADDR_CTRL) begin
                nxt_st.port_control_two = bus.wdata;
            end else if (bus.addr == `UARX_ADDR_BAUD) begin
                nxt_st.baud = bus.wdata[7:0];
            end
        end

        // Read data one cycle after the strobe
        if (bus.rd) begin
            if (bus.addr == `UARX_ADDR_STATUS) begin
                nxt_st.rdata[`UARX_ST_AVAIL] = st_ff.receive_available_flag;
                nxt_st.rdata[`UARX_ST_OVR] = st_ff.overrun_flag;
                nxt_st.rdata[`UARX_ST_NOISE] = st_ff.noise_flag;
                nxt_st.rdata[`UARX_ST_FRAME] = head.fr_err & ~empty;
                nxt_st.rdata[`UARX_ST_PAR] = head.pa_err & ~empty;
                nxt_st.rdata[`UARX_ST_IDLE] = st_ff.receive_idle_flag;
                nxt_st.rdata[`UARX_ST_TXIF] = tx_empty_i;
                nxt_st.rdata[`UARX_ST_TIDLE] = tx_idle_i;
            end else if (bus.addr == `UARX_ADDR_DATA) begin
                nxt_st.rdata = {1'b0, head.data};
            end else if (bus.addr == `UARX_ADDR_CTRL) begin
                nxt_st.rdata = st_ff.port_control_two;
            end else begin
                nxt_st.rdata = {2'h0, st_ff.baud};
            end
        end
    end

    // Synchronous reset to idle search
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_ff <= '0;
            st_ff.state <= uarx_pkg::UARX_IDLE;
            st_ff.receive_idle_flag <= 1'b1;
            st_ff.irq_n <= 1'b1;
            st_ff.line_d <= 1'b1;
            st_ff.port_control_two <= `UARX_CTRL_RESET;
            st_ff.baud <= `UARX_BAUD_RESET;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign irq_n_o = st_ff.irq_n;
    assign receive_idle_flag_o = st_ff.receive_idle_flag;
endmodule

/* uarx_core_chk.sv */
// Port-level assertions for the receive status and interrupt block
`timescale 1ns/1ps
module uarx_core_chk (
    // Clock and control
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic port_clock_run_i,
    // Register port
    input wire logic [1:0] addr_i,
    input wire logic [9:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [9:0] rdata_o,
    // Transmitter, line and interrupt
    input wire logic tx_empty_i,
    input wire logic tx_idle_i,
    input wire logic rx_pin_i,
    input wire logic irq_n_o,
    input wire logic receive_idle_flag_o
);
    logic [9:0] ctrl_ff;

    // Shadow of the control register, so enables can be judged from the ports
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ctrl_ff <= 10'h000;
        end else if (ce_i && wr_i && addr_i == 2'h2) begin
            ctrl_ff <= wdata_i;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // Interrupt steps: one low cycle, then back high
    sequence s_irq_pulse;
        !irq_n_o ##1 irq_n_o;
    endsequence
    // Wake armed: clock stopped, wake, receive enable and interrupt enable set
    sequence s_wake_edge;
        !port_clock_run_i && ctrl_ff[8] && ctrl_ff[9] && ctrl_ff[4] && $fell(rx_pin_i);
    endsequence

    a_irq_one_pulse: assert property (!irq_n_o |=> irq_n_o)
        else $error("interrupt low for more than one cycle");
    a_reset_quiet_outputs: assert property ($past(srst_i) |-> irq_n_o && receive_idle_flag_o && rdata_o == 10'h000)
        else $error("outputs not at rest after reset");
    a_rdata_only_answer: assert property (!$past(rd_i && ce_i) |-> rdata_o == 10'h000)
        else $error("read data present without a read");
    a_idle_needs_start: assert property ($fell(receive_idle_flag_o) |-> !$past(rx_pin_i, 2))
        else $error("idle flag dropped without a start bit");
    a_status_idle_bit: assert property ($past(rd_i && ce_i && addr_i == 2'h0) |-> rdata_o[5] == $past(receive_idle_flag_o))
        else $error("status idle bit disagrees with idle flag");
    a_irq_needs_enable: assert property ($fell(irq_n_o) |-> ctrl_ff[4] || ctrl_ff[6] || ctrl_ff[7])
        else $error("interrupt with every enable clear");
    a_tx_empty_irq: assert property (ce_i && ctrl_ff[6] && $rose(tx_empty_i) |-> ##[1:3] !irq_n_o)
        else $error("transmit empty interrupt missing");
    a_tx_idle_irq: assert property (ce_i && ctrl_ff[7] && $rose(tx_idle_i) |-> ##[1:3] s_irq_pulse)
        else $error("transmit idle interrupt missing");
    a_wake_pin_irq: assert property (s_wake_edge |-> ##[1:8] s_irq_pulse)
        else $error("wake edge interrupt missing");
endmodule

/* uarx_remote_tx.sv */
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module uarx_remote_tx #(
    parameter int BIT_CYC = 16
) (
    // Clock and request
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic [31:0] frame_i,
    input wire logic [5:0] len_i,
    input wire logic noise_i,
    // Line
    output logic line_o,
    output logic busy_o
);
    initial begin
        line_o = 1'b1;
        busy_o = 1'b0;
    end

    // Frame bits go out first to last; a noise glitch hits mid first data bit
    always @(posedge clock_i) begin
        if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            for (int b = 0; b < len_i; b++) begin
                for (int t = 0; t < BIT_CYC; t++) begin
                    line_o <= frame_i[b] ^ (noise_i && b == 1 && t == 7);
                    @(posedge clock_i);
                end
            end
            line_o <= 1'b1; // Line idles high between frames
            busy_o <= 1'b0;
        end
    end
endmodule

/* uart_receiver_status_interrupts_tb.sv */
// Self-checking testbench for the receive status and interrupt block
`timescale 1ns/1ps
module uart_receiver_status_interrupts_tb;
    localparam int BIT = 16; // Baud divisor 0 gives sixteen cycles a bit
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic run = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [9:0] wdata = 10'h000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [9:0] rdata;
    logic tx_empty = 1'b0;
    logic tx_idle = 1'b0;
    logic line;
    logic irq_n;
    logic idle;
    logic go = 1'b0;
    logic [31:0] frame = 32'h0;
    logic [5:0] len = 6'h0A;
    logic noise = 1'b0;
    logic busy;
    int errors = 0;
    int samples_checked = 0;
    int irq_cnt = 0;
    int cycles = 0;

    uarx_core uarx_core_i (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i), .port_clock_run_i(run),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_empty_i(tx_empty),
        .tx_idle_i(tx_idle), .rx_pin_i(line), .irq_n_o(irq_n), .receive_idle_flag_o(idle));
    uarx_remote_tx #(.BIT_CYC(BIT)) uarx_remote_tx_i (.clock_i(clock_i), .go_i(go), .frame_i(frame),
        .len_i(len), .noise_i(noise), .line_o(line), .busy_o(busy));

    always #25 clock_i = ~clock_i;

    // Count interrupt pulses; a hang is cut short well past the expected run
    always @(posedge clock_i) begin
        if (!irq_n) begin
            irq_cnt++;
        end
        cycles++;
        if (cycles == 30000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Register port cycles; read data is taken in the cycle after the strobe
    task automatic wr_reg(input logic [1:0] a, input logic [9:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [9:0] exp, input string what);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
        @(posedge clock_i);
    endtask

    // One frame from the far side; idle must be low part way through it
    task automatic send(input logic [31:0] f, input logic [5:0] n, input logic nz);
        frame <= f;
        len <= n;
        noise <= nz;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        repeat (5 * BIT) @(posedge clock_i);
        #1;
        chk({9'h000, idle}, 10'h000, "idle in frame");
        while (busy) @(posedge clock_i);
        repeat (BIT) @(posedge clock_i);
    endtask
    task automatic tx8(input logic [7:0] d);
        send({22'h0, 1'b1, d, 1'b0}, 6'h0A, 1'b0);
    endtask

    task automatic t_reset();
        rd_reg(2'h0, 10'h020, "status reset");
        rd_reg(2'h2, 10'h000, "control reset");
        rd_reg(2'h3, 10'h000, "baud reset");
        wr_reg(2'h0, 10'h3FF);
        rd_reg(2'h0, 10'h020, "status read-only");
        $display("test reset done");
    endtask

    task automatic t_receive();
        wr_reg(2'h2, 10'h210);
        irq_cnt = 0;
        tx8(8'h35);
        chk(10'(irq_cnt), 10'h001, "receive irq");
        rd_reg(2'h0, 10'h021, "status avail");
        rd_reg(2'h1, 10'h035, "data lsb first");
        rd_reg(2'h0, 10'h020, "avail cleared");
        $display("test receive done");
    endtask

    task automatic t_overrun();
        tx8(8'h11);
        tx8(8'h22);
        irq_cnt = 0;
        tx8(8'h33);
        chk({9'h000, irq_cnt > 0}, 10'h001, "overrun irq");
        rd_reg(2'h0, 10'h023, "overrun set");
        rd_reg(2'h1, 10'h011, "first kept");
        rd_reg(2'h1, 10'h022, "peek no pop");
        rd_reg(2'h0, 10'h021, "overrun cleared");
        rd_reg(2'h1, 10'h022, "second kept");
        rd_reg(2'h0, 10'h020, "third dropped");
        $display("test overrun done");
    endtask

    task automatic t_errors();
        send({22'h0, 1'b1, 8'hC3, 1'b0}, 6'h0A, 1'b1);
        rd_reg(2'h0, 10'h025, "noise set");
        rd_reg(2'h1, 10'h0C3, "noisy word");
        rd_reg(2'h0, 10'h020, "noise cleared");
        send({22'h0, 1'b0, 8'h5C, 1'b0}, 6'h0A, 1'b0);
        rd_reg(2'h0, 10'h029, "stop low");
        rd_reg(2'h1, 10'h05C, "framed word");
        wr_reg(2'h2, 10'h218);
        send({21'h0, 2'b01, 8'h6D, 1'b0}, 6'h0B, 1'b0);
        send({21'h0, 2'b11, 8'h7E, 1'b0}, 6'h0B, 1'b0);
        rd_reg(2'h0, 10'h029, "second stop low");
        rd_reg(2'h1, 10'h06D, "word one");
        rd_reg(2'h0, 10'h021, "error per word");
        rd_reg(2'h1, 10'h07E, "word two");
        wr_reg(2'h2, 10'h212);
        send({21'h0, 2'b11, 8'h03, 1'b0}, 6'h0B, 1'b0);
        rd_reg(2'h0, 10'h031, "even parity bad");
        rd_reg(2'h1, 10'h003, "parity word");
        wr_reg(2'h2, 10'h216);
        send({21'h0, 2'b11, 8'h03, 1'b0}, 6'h0B, 1'b0);
        rd_reg(2'h0, 10'h021, "odd parity good");
        rd_reg(2'h1, 10'h003, "parity word");
        $display("test errors done");
    endtask

    task automatic t_break();
        wr_reg(2'h2, 10'h210);
        irq_cnt = 0;
        send(32'h0, 6'd30, 1'b0);
        tx8(8'h5A);
        chk({9'h000, irq_cnt > 0}, 10'h001, "break irq");
        rd_reg(2'h0, 10'h029, "break status");
        rd_reg(2'h1, 10'h000, "break zeros");
        rd_reg(2'h0, 10'h021, "one word after");
        rd_reg(2'h1, 10'h05A, "word after break");
        rd_reg(2'h0, 10'h020, "no extra word");
        $display("test break done");
    endtask

    task automatic t_address();
        wr_reg(2'h2, 10'h231); // Parity kept off in address mode
        irq_cnt = 0;
        send({21'h0, 1'b1, 9'h0AA, 1'b0}, 6'h0B, 1'b0);
        chk(10'(irq_cnt), 10'h000, "data word quiet");
        rd_reg(2'h0, 10'h021, "status");
        rd_reg(2'h1, 10'h0AA, "nine bit data");
        send({21'h0, 1'b1, 9'h1AA, 1'b0}, 6'h0B, 1'b0);
        chk(10'(irq_cnt), 10'h001, "address irq");
        rd_reg(2'h0, 10'h021, "status");
        rd_reg(2'h1, 10'h1AA, "ninth bit");
        wr_reg(2'h2, 10'h230);
        tx8(8'h80);
        chk(10'(irq_cnt), 10'h002, "eighth bit irq");
        rd_reg(2'h0, 10'h021, "status");
        rd_reg(2'h1, 10'h080, "eight bit address");
        $display("test address done");
    endtask

    task automatic t_tx_wake();
        wr_reg(2'h2, 10'h040);
        irq_cnt = 0;
        tx_empty <= 1'b1;
        repeat (4) @(posedge clock_i);
        tx_idle <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk(10'(irq_cnt), 10'h001, "own enables");
        rd_reg(2'h0, 10'h0E0, "tx status");
        wr_reg(2'h2, 10'h080);
        tx_idle <= 1'b0;
        @(posedge clock_i);
        tx_idle <= 1'b1;
        repeat (4) @(posedge clock_i);
        chk(10'(irq_cnt), 10'h002, "idle enable");
        // Wake: the receiver is paused, so only the falling edge matters
        wr_reg(2'h2, 10'h310);
        irq_cnt = 0;
        run <= 1'b0;
        frame <= {22'h0, 1'b1, 8'h00, 1'b0};
        len <= 6'h0A;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        repeat (20) @(posedge clock_i);
        chk(10'(irq_cnt), 10'h001, "wake irq");
        $display("test transmit and wake done");
    endtask

    initial begin
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        t_reset();
        t_receive();
        t_overrun();
        t_errors();
        t_break();
        t_address();
        t_tx_wake();
        give_verdict();
    end
endmodule

bind uarx_core uarx_core_chk uarx_core_chk_i (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
    .port_clock_run_i(port_clock_run_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .tx_empty_i(tx_empty_i), .tx_idle_i(tx_idle_i), .rx_pin_i(rx_pin_i),
    .irq_n_o(irq_n_o), .receive_idle_flag_o(receive_idle_flag_o));
